// ===== logic/ccb_pkg.sv
// Package: register map, field layout and codes for the cursor layer blender
package ccb_pkg;
   // ****************************************
   // Register byte addresses
   // ****************************************
   localparam logic [31:0] CCB_POS_ADR  = 32'hF803_8374;
   localparam logic [31:0] CCB_SIZE_ADR = 32'hF803_8378;
   localparam logic [31:0] CCB_STEP_ADR = 32'hF803_837C;
   localparam logic [31:0] CCB_DEF_ADR  = 32'hF803_8384;
   localparam logic [31:0] CCB_KEY_ADR  = 32'hF803_8388;
   localparam logic [31:0] CCB_MASK_ADR = 32'hF803_838C;
   localparam logic [31:0] CCB_CTL_ADR  = 32'hF803_8390;
   localparam logic [31:0] CCB_BASE_ADR = 32'hF803_8398;
   localparam logic [31:0] CCB_STAT_ADR = 32'hF803_839C;
   localparam logic [31:0] CCB_BLUT_ADR = 32'hF803_8400;
   localparam logic [31:0] CCB_OLUT_ADR = 32'hF803_8800;
   localparam logic [31:0] CCB_LUT_SPAN = 32'h0000_0400;
   localparam logic [31:0] CCB_REG_RST  = 32'h0000_0000;
   // ****************************************
   // Field layout
   // ****************************************
   localparam int CCB_LEFT_LSB = 0;
   localparam int CCB_TOP_LSB  = 16;
   localparam int CCB_POS_W    = 11;
   localparam int CCB_XSZ_LSB  = 0;
   localparam int CCB_YSZ_LSB  = 16;
   localparam int CCB_SZ_W     = 7;
   localparam int CCB_MATCH     = 0;
   localparam int CCB_CMPL      = 1;
   localparam int CCB_IT2BL     = 2;
   localparam int CCB_DIFF      = 3;
   localparam int CCB_REVA      = 4;
   localparam int CCB_GLB_EN    = 5;
   localparam int CCB_LOC_EN    = 6;
   localparam int CCB_OVL       = 7;
   localparam int CCB_DMA       = 8;
   localparam int CCB_FILL      = 9;
   localparam int CCB_DSTK      = 10;
   localparam int CCB_ALPHA_LSB = 16;
   localparam logic [31:0] CCB_CTL_MASK = 32'h00FF_07FF;
   localparam logic [31:0] CCB_RGB_MASK = 32'h00FF_FFFF;
   localparam logic [31:0] CCB_POS_MASK = 32'h07FF_07FF;
   localparam logic [31:0] CCB_SZ_MASK  = 32'h007F_007F;
   localparam logic [7:0]  CCB_FULL     = 8'hFF;
   // ****************************************
   // Source component depth codes
   // ****************************************
   typedef enum logic [1:0] {CCB_D4, CCB_D5, CCB_D6, CCB_D8} ccb_depth_t;
endpackage // ccb_pkg

// ===== logic/ccb_cursor_blend.sv
// Cursor layer window, keying and blend stage with its Wishbone register file
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
module ccb_cursor_blend
   import ccb_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Pixel stream in
   input  wire logic        pix_valid_i,
   input  wire logic        frame_start_i,
   input  wire logic [10:0] pix_x_i,
   input  wire logic [10:0] pix_y_i,
   input  wire logic [23:0] under_rgb_i,
   input  wire logic [23:0] dma_rgb_i,
   input  wire logic [1:0]  dma_depth_i,
   input  wire logic [7:0]  local_alpha_i,
   // Lookup read port
   input  wire logic [7:0]  lut_idx_i,
   // Pixel stream out
   output logic             pix_valid_o,
   output logic [23:0]      pix_rgb_o,
   output logic             pix_covered_o,
   // Cursor fetch control
   output logic             fetch_en_o,
   output logic [31:0]      fetch_addr_o,
   output logic             fetch_row_o,
   // Lookup read data
   output logic [23:0]      base_lut_o,
   output logic [31:0]      ovl1_lut_o
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [31:0] pos_ff, size_ff, step_ff, def_ff, key_ff, mask_ff, ctl_ff, base_ff;
   logic [31:0] rdat_ff, fetch_addr_ff, ovl1_rd_ff;
   logic [23:0] rgb_ff, difference_feedback_select_ff, blut_rd_ff;
   logic [1:0]  stat_ff;
   logic        ack_ff, vld_ff, cov_ff, row_ff, den_ff;
   logic        acc, wr, blut_hit, olut_hit;
   logic [7:0]  lut_wi;
   logic [31:0] blut_q [256];
   logic [31:0] olut_q [256];
   logic [10:0] x_lo, y_lo, x_hi, y_hi;
   logic        in_win, match_ovl, match_und, keyed, covered;
   logic [7:0]  alpha, ak;
   logic [15:0] gl_prod;
   logic [23:0] dma_exp, ovl_rgb, blended, result;
   logic [2:0]  m_ovl, m_und;

   // Merge write data into a register under byte enables
   function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel, input logic [31:0] keep);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r & keep;
   endfunction

   // Widen a shallow component to 8 bits
   function automatic logic [7:0] expand(input logic [7:0] c, input logic [1:0] d,
                                         input logic msb_fill_select);
      logic [7:0] e;
      e = c;
      case (d)
         CCB_D4: e = {c[3:0], msb_fill_select ? {4{c[3]}} : 4'h0};
         CCB_D5: e = {c[4:0], msb_fill_select ? {3{c[4]}} : 3'h0};
         CCB_D6: e = {c[5:0], msb_fill_select ? {2{c[5]}} : 2'h0};
         default: e = c;
      endcase
      return e;
   endfunction

   // One component through mixer, difference and adder stages; full alpha is exact
   function automatic logic [7:0] blend1(input logic [7:0] ov, input logic [7:0] un,
                                         input logic [7:0] it, input logic [7:0] a,
                                         input logic use_it, input logic add_it);
      logic [15:0] mix;
      logic [15:0] dm;
      logic [9:0]  s;
      mix = (&a) ? 16'(ov) : 16'((17'(ov) * 17'(a) + 17'(un) * 17'(CCB_FULL - a)) >> 8);
      dm  = (use_it ? it : 8'h00) * a;
      s   = 10'(mix[7:0]) + 10'(dm[15:8]) + (add_it ? 10'(it) : 10'h000);
      return (s > 10'(CCB_FULL)) ? CCB_FULL : s[7:0];
   endfunction

   // ****************************************
   // Wishbone slave
   // ****************************************
   // One answer per request; ack drops the cycle after it was given
   assign acc      = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr       = acc && wb_we_i;
   assign blut_hit = (wb_adr_i >= CCB_BLUT_ADR) && (wb_adr_i < CCB_BLUT_ADR + CCB_LUT_SPAN);
   assign olut_hit = (wb_adr_i >= CCB_OLUT_ADR) && (wb_adr_i < CCB_OLUT_ADR + CCB_LUT_SPAN);
   assign lut_wi   = wb_adr_i[9:2];

   // Ack generation
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= acc;
      end
   end

   // Control register writes; reserved bits stay zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_ff  <= CCB_REG_RST;
         size_ff <= CCB_REG_RST;
         step_ff <= CCB_REG_RST;
         def_ff  <= CCB_REG_RST;
         key_ff  <= CCB_REG_RST;
         mask_ff <= CCB_REG_RST;
         ctl_ff  <= CCB_REG_RST;
         base_ff <= CCB_REG_RST;
      end else if (wr) begin
         if (wb_adr_i == CCB_POS_ADR) begin
            pos_ff <= bmerge(pos_ff, wb_dat_i, wb_sel_i, CCB_POS_MASK);
         end else if (wb_adr_i == CCB_SIZE_ADR) begin
            size_ff <= bmerge(size_ff, wb_dat_i, wb_sel_i, CCB_SZ_MASK);
         end else if (wb_adr_i == CCB_STEP_ADR) begin
            step_ff <= bmerge(step_ff, wb_dat_i, wb_sel_i, '1);
         end else if (wb_adr_i == CCB_DEF_ADR) begin
            def_ff <= bmerge(def_ff, wb_dat_i, wb_sel_i, CCB_RGB_MASK);
         end else if (wb_adr_i == CCB_KEY_ADR) begin
            key_ff <= bmerge(key_ff, wb_dat_i, wb_sel_i, CCB_RGB_MASK);
         end else if (wb_adr_i == CCB_MASK_ADR) begin
            mask_ff <= bmerge(mask_ff, wb_dat_i, wb_sel_i, CCB_RGB_MASK);
         end else if (wb_adr_i == CCB_CTL_ADR) begin
            ctl_ff <= bmerge(ctl_ff, wb_dat_i, wb_sel_i, CCB_CTL_MASK);
         end else if (wb_adr_i == CCB_BASE_ADR) begin
            base_ff <= bmerge(base_ff, wb_dat_i, wb_sel_i, '1);
         end
      end
   end

   // Lookup tables, one flop word per entry
   for (genvar i = 0; i < 256; i++) begin : g_lut
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            blut_q[i] <= CCB_REG_RST;
            olut_q[i] <= CCB_REG_RST;
         end else if (wr && lut_wi == 8'(i)) begin
            if (blut_hit) begin
               blut_q[i] <= bmerge(blut_q[i], wb_dat_i, wb_sel_i, CCB_RGB_MASK);
            end
            if (olut_hit) begin
               olut_q[i] <= bmerge(olut_q[i], wb_dat_i, wb_sel_i, '1);
            end
         end
      end
   end

   // Read data; unmapped addresses answer zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_ff <= CCB_REG_RST;
      end else if (acc && !wb_we_i) begin
         if (wb_adr_i == CCB_POS_ADR) begin
            rdat_ff <= pos_ff;
         end else if (wb_adr_i == CCB_SIZE_ADR) begin
            rdat_ff <= size_ff;
         end else if (wb_adr_i == CCB_STEP_ADR) begin
            rdat_ff <= step_ff;
         end else if (wb_adr_i == CCB_DEF_ADR) begin
            rdat_ff <= def_ff;
         end else if (wb_adr_i == CCB_KEY_ADR) begin
            rdat_ff <= key_ff;
         end else if (wb_adr_i == CCB_MASK_ADR) begin
            rdat_ff <= mask_ff;
         end else if (wb_adr_i == CCB_CTL_ADR) begin
            rdat_ff <= ctl_ff;
         end else if (wb_adr_i == CCB_BASE_ADR) begin
            rdat_ff <= base_ff;
         end else if (wb_adr_i == CCB_STAT_ADR) begin
            rdat_ff <= {30'h0, stat_ff};
         end else if (blut_hit) begin
            rdat_ff <= blut_q[lut_wi];
         end else if (olut_hit) begin
            rdat_ff <= olut_q[lut_wi];
         end else begin
            rdat_ff <= CCB_REG_RST;
         end
      end
   end

   // ****************************************
   // Window and keying
   // ****************************************
   // Window bounds; size fields are 7 bits so 128 is the largest extent
   assign x_lo = pos_ff[CCB_LEFT_LSB +: CCB_POS_W];
   assign y_lo = pos_ff[CCB_TOP_LSB +: CCB_POS_W];
   assign x_hi = x_lo + 11'(size_ff[CCB_XSZ_LSB +: CCB_SZ_W]);
   assign y_hi = y_lo + 11'(size_ff[CCB_YSZ_LSB +: CCB_SZ_W]);
   // No wrap guard: software keeps the window inside the frame
   assign in_win = (pix_x_i >= x_lo) && (pix_x_i <= x_hi) &&
                   (pix_y_i >= y_lo) && (pix_y_i <= y_hi);

   // Overlay source and alpha selection
   assign ovl_rgb = (ctl_ff[CCB_OVL] && ctl_ff[CCB_DMA]) ? dma_exp : def_ff[23:0];
   assign gl_prod = ctl_ff[CCB_ALPHA_LSB +: 8] * local_alpha_i;
   always_comb begin
      if (ctl_ff[CCB_GLB_EN] && ctl_ff[CCB_LOC_EN]) begin
         alpha = gl_prod[15:8];
      end else if (ctl_ff[CCB_GLB_EN]) begin
         alpha = ctl_ff[CCB_ALPHA_LSB +: 8];
      end else if (ctl_ff[CCB_LOC_EN]) begin
         alpha = local_alpha_i;
      end else begin
         alpha = CCB_FULL;
      end
   end
   assign ak = ctl_ff[CCB_REVA] ? (CCB_FULL - alpha) : alpha;

   // Per-component expand, key compare and blend
   for (genvar c = 0; c < 3; c++) begin : g_comp
      assign dma_exp[8*c +: 8] = expand(dma_rgb_i[8*c +: 8], dma_depth_i, ctl_ff[CCB_FILL]);
      assign m_ovl[c] = ((ovl_rgb[8*c +: 8] ^ key_ff[8*c +: 8]) & mask_ff[8*c +: 8]) == 8'h00;
      assign m_und[c] = ((under_rgb_i[8*c +: 8] ^ key_ff[8*c +: 8]) & mask_ff[8*c +: 8]) == 8'h00;
      assign blended[8*c +: 8] = blend1(ovl_rgb[8*c +: 8], under_rgb_i[8*c +: 8],
                                        difference_feedback_select_ff[8*c +: 8], ak, ctl_ff[CCB_DIFF],
                                        ctl_ff[CCB_IT2BL]);
   end
   assign match_ovl = &m_ovl;
   assign match_und = &m_und;
   // Source keying hides keyed cursor pixels; destination keying shows only on keyed ground
   assign keyed   = ctl_ff[CCB_MATCH] &&
                    (ctl_ff[CCB_DSTK] ? !match_und : match_ovl);
   assign covered = in_win && !keyed;
   assign result  = ctl_ff[CCB_CMPL] ? ~blended : blended;

   // ****************************************
   // Pixel output stage
   // ****************************************
   // Registered pixel; uncovered pixels carry the lower layers through
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vld_ff <= 1'b0;
         cov_ff <= 1'b0;
         rgb_ff <= '0;
      end else begin
         vld_ff <= pix_valid_i;
         cov_ff <= pix_valid_i && covered;
         if (pix_valid_i) begin
            rgb_ff <= covered ? result : under_rgb_i;
         end
      end
   end

   // Iterated pixel feeds the next covered pixel; cleared per frame
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         difference_feedback_select_ff <= '0;
      end else if (frame_start_i) begin
         difference_feedback_select_ff <= '0;
      end else if (pix_valid_i && covered) begin
         difference_feedback_select_ff <= result;
      end
   end

   // Status: bit0 last pixel in window, bit1 last pixel keyed out
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_ff <= 2'b00;
      end else if (pix_valid_i) begin
         stat_ff <= {in_win && keyed, in_win};
      end
   end

   // ****************************************
   // Row fetch addressing
   // ****************************************
   // Address steps by the stride after each window row but the last
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fetch_addr_ff <= CCB_REG_RST;
         row_ff        <= 1'b0;
         den_ff        <= 1'b0;
      end else begin
         den_ff <= ctl_ff[CCB_DMA];
         row_ff <= 1'b0;
         if (frame_start_i) begin
            fetch_addr_ff <= base_ff;
         end else if (ctl_ff[CCB_DMA] && pix_valid_i && in_win &&
                      pix_x_i == x_hi && pix_y_i != y_hi) begin
            fetch_addr_ff <= fetch_addr_ff + step_ff;
            row_ff        <= 1'b1;
         end
      end
   end

   // Lookup read port, one cycle latency
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blut_rd_ff <= '0;
         ovl1_rd_ff <= '0;
      end else begin
         blut_rd_ff <= blut_q[lut_idx_i][23:0];
         ovl1_rd_ff <= olut_q[lut_idx_i];
      end
   end

   // Outputs straight from flops
   assign wb_ack_o      = ack_ff;
   assign wb_dat_o      = rdat_ff;
   assign pix_valid_o   = vld_ff;
   assign pix_rgb_o     = rgb_ff;
   assign pix_covered_o = cov_ff;
   assign fetch_en_o    = den_ff;
   assign fetch_addr_o  = fetch_addr_ff;
   assign fetch_row_o   = row_ff;
   assign base_lut_o    = blut_rd_ff;
   assign ovl1_lut_o    = ovl1_rd_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic plain;
   assign plain = !ctl_ff[CCB_MATCH] && !ctl_ff[CCB_IT2BL] && !ctl_ff[CCB_DIFF] &&
                  !ctl_ff[CCB_REVA] && !ctl_ff[CCB_GLB_EN] && !ctl_ff[CCB_LOC_EN];

   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   pass_through_a: assert property (pix_valid_i && !in_win |=>
                                    pix_rgb_o == $past(under_rgb_i) && !pix_covered_o)
      else $error("pixel outside window altered");
   width_edge_a: assert property (pix_valid_i && !ctl_ff[CCB_MATCH] && in_win &&
                                  pix_x_i == x_lo + 11'(size_ff[6:0]) |=> pix_covered_o)
      else $error("last window column not covered");
   height_edge_a: assert property (pix_valid_i && pix_y_i == y_lo + 11'(size_ff[22:16]) + 11'h1
                                   |=> !pix_covered_o)
      else $error("row below window covered");
   default_colour_a: assert property (pix_valid_i && in_win && plain && !ctl_ff[CCB_DMA] &&
                                      !ctl_ff[CCB_CMPL] |=> pix_rgb_o == $past(def_ff[23:0]))
      else $error("default colour not shown");
   invert_out_a: assert property (pix_valid_i && in_win && plain && !ctl_ff[CCB_DMA] &&
                                  ctl_ff[CCB_CMPL] |=> pix_rgb_o == ~$past(def_ff[23:0]))
      else $error("inverted output wrong");
   key_nomask_a: assert property (pix_valid_i && in_win && ctl_ff[CCB_MATCH] &&
                                  !ctl_ff[CCB_DSTK] && mask_ff[23:0] == 24'h0
                                  |=> !pix_covered_o)
      else $error("empty mask failed to match");
   key_off_a: assert property (pix_valid_i && in_win && !ctl_ff[CCB_MATCH]
                               |=> pix_covered_o)
      else $error("keying active while disabled");
   row_stride_a: assert property (fetch_row_o |->
                                  fetch_addr_o == $past(fetch_addr_o) + $past(step_ff))
      else $error("row address step wrong");
   lut_write_a: assert property (wr && blut_hit && wb_sel_i == 4'hF && lut_idx_i == lut_wi
                                 ##1 lut_idx_i == $past(lut_idx_i)
                                 |=> base_lut_o == $past(wb_dat_i[23:0], 2))
      else $error("base table entry not stored");

   cov_pixel_c: cover property (pix_valid_i && covered);
   cov_keyed_c: cover property (pix_valid_i && in_win && keyed);
   cov_row_c:   cover property (fetch_row_o);
   cov_olut_c:  cover property (wr && olut_hit ##1 wb_ack_o);
endmodule // ccb_cursor_blend

// ===== tb/ccb_cursor_blend_test.sv
// Self-checking bench for the cursor layer blender and its registers
`timescale 1ns/100ps
module ccb_cursor_blend_test;
   import ccb_pkg::*;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   localparam logic [23:0] DC = 24'h204080;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        pv = 1'b0, fs = 1'b0, ack, pvo, cov, fen, frw;
   logic [3:0]  sel = 4'h0;
   logic [1:0]  dep = 2'h3;
   logic [7:0]  la = 8'h00, idx = 8'h00;
   logic [10:0] px = 11'h000, py = 11'h000;
   logic [23:0] und = 24'h0, dma = 24'h0, rgb, bl;
   logic [31:0] adr = 32'h0, dw = 32'h0, dr, fad, ol;
   int          fail_count = 0, comparisons = 0;
   ccb_cursor_blend i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .pix_valid_i(pv), .frame_start_i(fs), .pix_x_i(px), .pix_y_i(py),
      .under_rgb_i(und), .dma_rgb_i(dma), .dma_depth_i(dep), .local_alpha_i(la),
      .lut_idx_i(idx), .pix_valid_o(pvo), .pix_rgb_o(rgb), .pix_covered_o(cov),
      .fetch_en_o(fen), .fetch_addr_o(fad), .fetch_row_o(frw), .base_lut_o(bl),
      .ovl1_lut_o(ol));
   // 200 MHz clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // ****************************************
   // Checks, bus and pixel helpers
   // ****************************************
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Request held until ack is seen, so no answer latency is assumed
   task automatic wb_acc(input logic w, input logic [31:0] a, input logic [31:0] d,
                         output logic [31:0] q);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dw  <= d;
      sel <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         fail_count++;
         $display("[ERR] %0t ns: bus answer missing", $time);
         summarize();
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_acc(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb_acc(1'b0, a, 32'h0, q);
      chk_word(q, e);
   endtask
   task automatic pix(input logic [10:0] x, input logic [10:0] y, input logic [23:0] u);
      @(posedge clk_i);
      pv  <= 1'b1;
      px  <= x;
      py  <= y;
      und <= u;
      @(posedge clk_i);
      pv <= 1'b0;
      #1;
   endtask
   task automatic frame;
      @(posedge clk_i);
      fs <= 1'b1;
      @(posedge clk_i);
      fs <= 1'b0;
      #1;
   endtask
   // Reference blend per component, saturating at full scale
   function automatic logic [23:0] mix(input logic [23:0] o, input logic [23:0] u,
         input logic [23:0] it, input int a, input bit dif, input bit add);
      int s;
      logic [23:0] r;
      for (int k = 0; k < 24; k += 8) begin
         s = (a == 255) ? o[k+:8] : (o[k+:8] * a + u[k+:8] * (255 - a)) >> 8;
         if (dif) s += (it[k+:8] * a) >> 8;
         if (add) s += it[k+:8];
         r[k+:8] = (s > 255) ? 8'hFF : s[7:0];
      end
      return r;
   endfunction
   function automatic logic [7:0] grow(input logic [7:0] v, input int w, input bit msb_fill_select);
      logic [7:0] c;
      c = (v & (8'hFF >> (8 - w))) << (8 - w);
      if (msb_fill_select && v[w-1]) c = c | (8'hFF >> w);
      return c;
   endfunction
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      logic [31:0] a [8] = '{CCB_SIZE_ADR, CCB_STEP_ADR, CCB_DEF_ADR, CCB_KEY_ADR,
                             CCB_MASK_ADR, CCB_CTL_ADR, CCB_BLUT_ADR, CCB_OLUT_ADR};
      foreach (a[i]) rd(a[i], CCB_REG_RST);
      wr(CCB_SIZE_ADR, 32'hFFFF_FFFF);
      rd(CCB_SIZE_ADR, CCB_SZ_MASK);
      wr(CCB_CTL_ADR, 32'hFFFF_FFFF);
      rd(CCB_CTL_ADR, CCB_CTL_MASK);
      wr(CCB_STEP_ADR, 32'hFFFF_FFFF);
      rd(CCB_STEP_ADR, 32'hFFFF_FFFF);
      wr(32'hF803_83A0, 32'h1234_5678);
      rd(32'hF803_83A0, 32'h0000_0000);
      idx <= 8'h03;
      wr(CCB_BLUT_ADR + 32'h0C, 32'hFFFF_FFFF);
      rd(CCB_BLUT_ADR + 32'h0C, 32'h00FF_FFFF);
      wr(CCB_OLUT_ADR + 32'h3FC, 32'hA1B2_C3D4);
      rd(CCB_OLUT_ADR + 32'h3FC, 32'hA1B2_C3D4);
      idx <= 8'h03;
      repeat (2) @(posedge clk_i);
      #1;
      chk_word({8'h00, bl}, 32'h00FF_FFFF);
      idx <= 8'hFF;
      repeat (2) @(posedge clk_i);
      #1;
      chk_word(ol, 32'hA1B2_C3D4);
   endtask
   // Top-left and bottom-right window corners and one step past each edge
   task automatic t_win;
      logic [10:0] xs [6] = '{13, 14, 13, 9, 10, 10};
      logic [10:0] ys [6] = '{6, 6, 7, 5, 5, 4};
      logic        in [6] = '{1, 0, 0, 0, 1, 0};
      wr(CCB_POS_ADR, 32'h0005_000A);
      wr(CCB_SIZE_ADR, 32'h0001_0003);
      wr(CCB_DEF_ADR, {8'h00, DC});
      wr(CCB_CTL_ADR, 32'h0);
      foreach (xs[i]) begin
         pix(xs[i], ys[i], 24'h0A0B0C);
         chk_bit(cov, in[i]);
         chk_word({8'h00, rgb}, {8'h00, in[i] ? mix(DC, 24'h0A0B0C, 0, 255, 0, 0)
                  : 24'h0A0B0C});
      end
      chk_bit(pvo, 1'b1);
   endtask
   task automatic key1(input logic [31:0] c, input logic [31:0] m, input logic [23:0] u,
                       input logic e);
      wr(CCB_CTL_ADR, c);
      wr(CCB_MASK_ADR, m);
      pix(11'd10, 11'd5, u);
      chk_bit(cov, e);
   endtask
   task automatic t_key;
      wr(CCB_KEY_ADR, 32'h0020_4081);
      key1(32'h1, 32'h00FF_FFFE, 24'h0, 1'b0);
      key1(32'h1, 32'h00FF_FFFF, 24'h0, 1'b1);
      key1(32'h0, 32'h00FF_FFFE, 24'h0, 1'b1);
      key1(32'h401, 32'h00FF_FFFE, 24'h204081, 1'b1);
      key1(32'h401, 32'h00FF_FFFE, 24'h000000, 1'b0);
      key1(32'h1, 32'h0, 24'h0, 1'b0);
   endtask
   task automatic t_alpha;
      logic [31:0] c [6] = '{32'h0, 32'h0040_0020, 32'h0040_0030, 32'h40, 32'h0040_0060,
                             32'h2};
      int          a [6] = '{255, 64, 191, 128, 32, 255};
      la <= 8'h80;
      foreach (c[i]) begin
         wr(CCB_CTL_ADR, c[i]);
         pix(11'd10, 11'd5, 24'h0A0B0C);
         chk_word({8'h00, rgb}, {8'h00, (i == 5) ? ~mix(DC, 24'h0A0B0C, 0, 255, 0, 0)
                  : mix(DC, 24'h0A0B0C, 0, a[i], 0, 0)});
      end
   endtask
   // Second pixel feeds back the first; frame start clears it
   task automatic t_difference_feedback_select;
      logic [23:0] r1;
      r1 = mix(DC, 24'h0, 24'h0, 255, 0, 0);
      for (int k = 0; k < 2; k++) begin
         wr(CCB_CTL_ADR, k ? 32'h8 : 32'h4);
         frame();
         pix(11'd10, 11'd5, 24'h0);
         chk_word({8'h00, rgb}, {8'h00, r1});
         pix(11'd10, 11'd5, 24'h0);
         chk_word({8'h00, rgb}, {8'h00, mix(DC, 24'h0, r1, 255, k == 1, k == 0)});
      end
   endtask
   task automatic t_dma;
      int          w [4] = '{4, 5, 6, 8};
      logic [23:0] e;
      dma <= 24'h2B2B2B;
      for (int d = 0; d < 4; d++) begin
         for (int r = 0; r < 2; r++) begin
            wr(CCB_CTL_ADR, 32'h180 | (r << CCB_FILL));
            dep <= d[1:0];
            e = {3{grow(8'h2B, w[d], r[0])}};
            pix(11'd10, 11'd5, 24'h0);
            chk_word({8'h00, rgb}, {8'h00, mix(e, 24'h0, 24'h0, 255, 0, 0)});
         end
      end
      chk_bit(fen, 1'b1);
      wr(CCB_CTL_ADR, 32'h100);
      pix(11'd10, 11'd5, 24'h0);
      chk_word({8'h00, rgb}, {8'h00, mix(DC, 24'h0, 24'h0, 255, 0, 0)});
      wr(CCB_CTL_ADR, 32'h80);
      pix(11'd10, 11'd5, 24'h0);
      chk_word({8'h00, rgb}, {8'h00, mix(DC, 24'h0, 24'h0, 255, 0, 0)});
      chk_bit(fen, 1'b0);
   endtask
   task automatic t_fetch;
      wr(CCB_BASE_ADR, 32'h0000_1000);
      wr(CCB_STEP_ADR, 32'h0000_0040);
      wr(CCB_POS_ADR, 32'h0);
      wr(CCB_SIZE_ADR, 32'h0001_0001);
      wr(CCB_CTL_ADR, 32'h100);
      frame();
      chk_word(fad, 32'h0000_1000);
      pix(11'd1, 11'd0, 24'h0);
      chk_word(fad, 32'h0000_1040);
      chk_bit(frw, 1'b1);
      pix(11'd1, 11'd1, 24'h0);
      chk_word(fad, 32'h0000_1040);
      chk_bit(frw, 1'b0);
   endtask
   // Main sequence: reset for two cycles, then every scenario
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_win();
      t_key();
      t_alpha();
      t_difference_feedback_select();
      t_dma();
      t_fetch();
      summarize();
   end
endmodule // ccb_cursor_blend_test
